// *** pkg/shift_store_defs.svh ***
`ifndef SHIFT_STORE_DEFS_SVH
`define SHIFT_STORE_DEFS_SVH

// ----------------------------------------
// Opcode bytes; single shift groups as opcode[7:1]
// ----------------------------------------
`define OPC_ESCAPE        8'h0F
`define OPC_SETB_NEG      8'h98
`define OPC_TABLE_GRP     8'h01
`define OPC_LOCAL_GRP     8'h00
`define OPC_SHIFT_LEFT_DOUBLE_IMM      8'hA4
`define OPC_SHIFT_LEFT_DOUBLE_CNT      8'hA5
`define OPC_SHIFT_RIGHT_DOUBLE_IMM      8'hAC
`define OPC_SHIFT_RIGHT_DOUBLE_CNT      8'hAD
`define OPC_SHIFT_ONE     7'h68
`define OPC_SHIFT_CNT     7'h69
`define OPC_SHIFT_IMM     7'h60

// ----------------------------------------
// ModR/M register field codes
// ----------------------------------------
`define REG_GLOBAL        3'h0
`define REG_INTR          3'h1
`define REG_MSTATUS       3'h4
`define REG_SETB          3'h0
`define REG_LOCAL         3'h0
`define REG_SHL           3'h4
`define REG_SHR           3'h5

// ----------------------------------------
// Clock counts: register / cache hit / miss
// ----------------------------------------
`define CLK_SETB_REG      3'h2
`define CLK_SETB_HIT      3'h2
`define CLK_SETB_MISS     3'h2
`define CLK_TABLE         3'h6
`define CLK_STORE_REG     3'h1
`define CLK_STORE_HIT     3'h2
`define CLK_STORE_MISS    3'h2
`define CLK_SH1_REG       3'h2
`define CLK_SH1_HIT       3'h4
`define CLK_SH1_MISS      3'h6
`define CLK_SHC_REG       3'h3
`define CLK_SHC_HIT       3'h5
`define CLK_SHC_MISS      3'h7
`define CLK_SHR_IMM_MISS_R 3'h5
`define CLK_DBL_REG       3'h1
`define CLK_DBL_HIT       3'h3
`define CLK_DBL_MISS      3'h5

// ----------------------------------------
// Lengths and masks
// ----------------------------------------
`define LEN_DISP8         3'h1
`define LEN_DISP16        3'h2
`define LEN_DISP32        3'h4
`define CNT_MASK          5'h1F
`define MOD_REGISTER      2'h3

`endif

// *** pkg/shift_store_pkg.sv ***
`default_nettype none
package shift_store_pkg;

   // Decoded operation
   typedef enum logic [3:0] {
      OP_NONE,
      OP_SET_BYTE_ON_NEGATIVE,
      OP_STORE_GLOBAL_TABLE_REG,
      OP_STORE_INTERRUPT_TABLE_REG,
      OP_STORE_LOCAL_TABLE_REG,
      OP_STORE_MACHINE_STATUS,
      OP_SHIFT_LEFT_LOGICAL,
      OP_SHIFT_RIGHT_LOGICAL,
      OP_SHIFT_LEFT_DOUBLE,
      OP_SHIFT_RIGHT_DOUBLE
   } op_t;

   // Where a shift count comes from
   typedef enum logic [1:0] {
      CNT_NONE,
      CNT_ONE,
      CNT_COUNT_LOW_REGISTER,
      CNT_IMMEDIATE
   } count_src_t;

   // Flags written by the instruction (1 = modified)
   typedef struct packed {
      logic overflow_flag;
      logic sign_flag;
      logic zero_flag;
      logic aux_carry_flag;
      logic parity_flag;
      logic carry_flag;
   } flag_mask_t;

   // Instruction bytes as seen by the decoder
   typedef struct packed {
      logic       valid;
      logic       escape;      // First byte was the two-byte escape
      logic [7:0] opcode;
      logic [7:0] modrm;
      logic [7:0] sib;
      logic [7:0] imm;
      logic       addr32;      // 32-bit addressing form
      logic       prot_mode;
      logic       cache_miss;
      logic [7:0] count_low;   // Value of the count register
   } insn_in_t;

   // Decode result
   typedef struct packed {
      logic       valid;
      logic       illegal;
      op_t        op;
      count_src_t count_src;
      logic [4:0] shift_count;
      logic       wide;
      flag_mask_t flags;
      logic [2:0] clocks;
      logic [3:0] length;
   } decode_out_t;

endpackage
`default_nettype wire

// *** core/shift_store_insn_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "shift_store_defs.svh"

module shift_store_insn_decode (
   // Clock and reset
   input  wire logic                        i_core_clk,
   input  wire logic                        i_rst_n,
   // Instruction in
   input  wire shift_store_pkg::insn_in_t   i_insn,
   // Decode result out
   output logic                             o_valid,
   output shift_store_pkg::decode_out_t     o_result
);
   import shift_store_pkg::*;

   // ----------------------------------------
   // Field extraction
   // ----------------------------------------
   logic [1:0] mod_f;
   logic [2:0] reg_f;
   logic [2:0] rm_f;
   logic       is_reg;
   logic       w_bit;

   assign mod_f  = i_insn.modrm[7:6];
   assign reg_f  = i_insn.modrm[5:3];
   assign rm_f   = i_insn.modrm[2:0];
   assign is_reg = (mod_f == `MOD_REGISTER);
   assign w_bit  = i_insn.opcode[0];

   // ----------------------------------------
   // Operation decode
   // ----------------------------------------
   op_t        op_d;
   count_src_t src_d;
   logic       illegal_d;

   // Unknown encodings flag illegal so the front end can trap
   always_comb begin
      op_d      = OP_NONE;
      src_d     = CNT_NONE;
      illegal_d = 1'b0;
      if (i_insn.escape) begin
         case (i_insn.opcode)
            `OPC_SETB_NEG: begin
               if (reg_f == `REG_SETB) op_d = OP_SET_BYTE_ON_NEGATIVE;
            end
            `OPC_TABLE_GRP: begin
               case (reg_f)
                  `REG_GLOBAL:  op_d = OP_STORE_GLOBAL_TABLE_REG;
                  `REG_INTR:    op_d = OP_STORE_INTERRUPT_TABLE_REG;
                  `REG_MSTATUS: op_d = OP_STORE_MACHINE_STATUS;
                  default:      op_d = OP_NONE;
               endcase
            end
            `OPC_LOCAL_GRP: begin
               // Only timed in protected mode; real mode treats it as illegal
               if (reg_f == `REG_LOCAL && i_insn.prot_mode) op_d = OP_STORE_LOCAL_TABLE_REG;
            end
            `OPC_SHIFT_LEFT_DOUBLE_IMM: begin
               op_d  = OP_SHIFT_LEFT_DOUBLE;
               src_d = CNT_IMMEDIATE;
            end
            `OPC_SHIFT_LEFT_DOUBLE_CNT: begin
               op_d  = OP_SHIFT_LEFT_DOUBLE;
               src_d = CNT_COUNT_LOW_REGISTER;
            end
            `OPC_SHIFT_RIGHT_DOUBLE_IMM: begin
               op_d  = OP_SHIFT_RIGHT_DOUBLE;
               src_d = CNT_IMMEDIATE;
            end
            `OPC_SHIFT_RIGHT_DOUBLE_CNT: begin
               op_d  = OP_SHIFT_RIGHT_DOUBLE;
               src_d = CNT_COUNT_LOW_REGISTER;
            end
            default: op_d = OP_NONE;
         endcase
      end else begin
         case (i_insn.opcode[7:1])
            `OPC_SHIFT_ONE: src_d = CNT_ONE;
            `OPC_SHIFT_CNT: src_d = CNT_COUNT_LOW_REGISTER;
            `OPC_SHIFT_IMM: src_d = CNT_IMMEDIATE;
            default:        src_d = CNT_NONE;
         endcase
         if (src_d != CNT_NONE) begin
            case (reg_f)
               `REG_SHL: op_d = OP_SHIFT_LEFT_LOGICAL;
               `REG_SHR: op_d = OP_SHIFT_RIGHT_LOGICAL;
               default:  op_d = OP_NONE;
            endcase
         end
         if (op_d == OP_NONE) src_d = CNT_NONE;
      end
      illegal_d = (op_d == OP_NONE);
   end

   // ----------------------------------------
   // Clock count
   // ----------------------------------------
   logic [2:0] clocks_d;

   // Pick register, hit or miss column of a triple
   function automatic logic [2:0] pick(input logic [2:0] r, input logic [2:0] h,
                                       input logic [2:0] m, input logic reg_op, input logic miss);
      if (reg_op)    return r;
      else if (miss) return m;
      else           return h;
   endfunction

   always_comb begin
      clocks_d = 3'h0;
      case (op_d)
         OP_SET_BYTE_ON_NEGATIVE:
            clocks_d = pick(`CLK_SETB_REG, `CLK_SETB_HIT, `CLK_SETB_MISS, is_reg, i_insn.cache_miss);
         OP_STORE_GLOBAL_TABLE_REG, OP_STORE_INTERRUPT_TABLE_REG:
            clocks_d = `CLK_TABLE;
         OP_STORE_LOCAL_TABLE_REG, OP_STORE_MACHINE_STATUS:
            clocks_d = pick(`CLK_STORE_REG, `CLK_STORE_HIT, `CLK_STORE_MISS,
                            is_reg, i_insn.cache_miss);
         OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL: begin
            if (src_d == CNT_COUNT_LOW_REGISTER)
               clocks_d = pick(`CLK_SHC_REG, `CLK_SHC_HIT, `CLK_SHC_MISS, is_reg, i_insn.cache_miss);
            else
               clocks_d = pick(`CLK_SH1_REG, `CLK_SH1_HIT, `CLK_SH1_MISS, is_reg, i_insn.cache_miss);
            // Right shift by immediate misses one clock faster in real mode
            if (op_d == OP_SHIFT_RIGHT_LOGICAL && src_d == CNT_IMMEDIATE && !is_reg
                && i_insn.cache_miss && !i_insn.prot_mode)
               clocks_d = `CLK_SHR_IMM_MISS_R;
         end
         OP_SHIFT_LEFT_DOUBLE, OP_SHIFT_RIGHT_DOUBLE: begin
            if (src_d == CNT_COUNT_LOW_REGISTER)
               clocks_d = pick(`CLK_SHC_REG, `CLK_SHC_HIT, `CLK_SHC_MISS, is_reg, i_insn.cache_miss);
            else
               clocks_d = pick(`CLK_DBL_REG, `CLK_DBL_HIT, `CLK_DBL_MISS, is_reg, i_insn.cache_miss);
         end
         default: clocks_d = 3'h0;
      endcase
   end

   // ----------------------------------------
   // Length: opcode, ModR/M, SIB, displacement, immediate
   // ----------------------------------------
   logic [3:0] len_d;
   logic [2:0] disp_d;
   logic       sib_d;

   always_comb begin
      disp_d = 3'h0;
      sib_d  = 1'b0;
      if (!is_reg) begin
         if (i_insn.addr32) begin
            sib_d = (rm_f == 3'h4);
            if (mod_f == 2'h1)      disp_d = `LEN_DISP8;
            else if (mod_f == 2'h2) disp_d = `LEN_DISP32;
            else if (rm_f == 3'h5 || (sib_d && i_insn.sib[2:0] == 3'h5))
               disp_d = `LEN_DISP32;
         end else begin
            if (mod_f == 2'h1)      disp_d = `LEN_DISP8;
            else if (mod_f == 2'h2) disp_d = `LEN_DISP16;
            else if (rm_f == 3'h6)  disp_d = `LEN_DISP16;
         end
      end
      // Immediate byte sits after any displacement
      len_d = 4'h2 + {3'h0, i_insn.escape} + {3'h0, sib_d} + {1'b0, disp_d}
              + {3'h0, (src_d == CNT_IMMEDIATE)};
   end

   // ----------------------------------------
   // Flags and shift count
   // ----------------------------------------
   flag_mask_t flags_d;
   logic [4:0] count_d;

   always_comb begin
      flags_d = '0;
      // Set-byte and stores leave every flag alone
      if (op_d == OP_SHIFT_LEFT_LOGICAL || op_d == OP_SHIFT_RIGHT_LOGICAL
          || op_d == OP_SHIFT_LEFT_DOUBLE || op_d == OP_SHIFT_RIGHT_DOUBLE)
         flags_d = '{overflow_flag: 1'b1, sign_flag: 1'b1, zero_flag: 1'b1,
                     aux_carry_flag: 1'b0, parity_flag: 1'b1, carry_flag: 1'b1};
      // Masking keeps large counts from stalling the shifter
      case (src_d)
         CNT_ONE:                count_d = 5'h01;
         CNT_COUNT_LOW_REGISTER: count_d = i_insn.count_low[4:0] & `CNT_MASK;
         CNT_IMMEDIATE:          count_d = i_insn.imm[4:0] & `CNT_MASK;
         default:                count_d = 5'h00;
      endcase
   end

   // ----------------------------------------
   // Output registers
   // ----------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_valid  <= 1'b0;
         o_result <= '0;
      end else begin
         o_valid              <= i_insn.valid;
         o_result.valid       <= i_insn.valid;
         o_result.illegal     <= i_insn.valid & illegal_d;
         o_result.op          <= op_d;
         o_result.count_src   <= src_d;
         o_result.shift_count <= count_d;
         // Set-byte is always a byte op; stores ignore w
         o_result.wide        <= i_insn.escape ? 1'b0 : w_bit;
         o_result.flags       <= flags_d;
         o_result.clocks      <= clocks_d;
         o_result.length      <= len_d;
      end
   end

endmodule
`default_nettype wire

// *** bench/shift_store_insn_decode_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module shift_store_insn_decode_monitor (
   // Clock and reset
   input wire logic                        i_core_clk,
   input wire logic                        i_rst_n,
   // Watched ports
   input wire shift_store_pkg::insn_in_t   i_insn,
   input wire logic                        o_valid,
   input wire shift_store_pkg::decode_out_t o_result
);
   import shift_store_pkg::*;
   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   logic [2:0] rg;
   logic       esc;
   logic       mem;
   logic       sh;
   assign rg  = i_insn.modrm[5:3];
   assign esc = i_insn.valid & i_insn.escape;
   assign mem = i_insn.modrm[7:6] != 2'h3;
   // Single shifts only; other D0-D3 groups belong elsewhere
   assign sh  = i_insn.valid & !i_insn.escape & (i_insn.opcode[7:1] inside {7'h68, 7'h69, 7'h60}) & rg[2] & !rg[1];
   // Single clock domain, so one default clocking covers all
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   AST_SETB: assert property (esc && i_insn.opcode == 8'h98 && rg == 3'h0 |=>
      o_result.op == OP_SET_BYTE_ON_NEGATIVE && o_result.clocks == 3'h2 && o_result.flags == 6'h00) else $error("set byte decode");
   AST_GLOBAL: assert property (esc && i_insn.opcode == 8'h01 && rg == 3'h0 |=>
      o_result.op == OP_STORE_GLOBAL_TABLE_REG && o_result.clocks == 3'h6) else $error("global store decode");
   AST_INTR: assert property (esc && i_insn.opcode == 8'h01 && rg == 3'h1 |=>
      o_result.op == OP_STORE_INTERRUPT_TABLE_REG && o_result.clocks == 3'h6) else $error("intr store decode");
   AST_MSTATUS: assert property (esc && i_insn.opcode == 8'h01 && rg == 3'h4 |=>
      o_result.clocks == ($past(mem) ? 3'h2 : 3'h1)) else $error("status store time");
   AST_LOCAL_REAL: assert property (esc && i_insn.opcode == 8'h00 && rg == 3'h0 && !i_insn.prot_mode |=>
      o_result.illegal && o_result.op == OP_NONE) else $error("local store in real mode");
   AST_FLAGS: assert property (sh |=> o_result.flags == 6'h3B [*1]) else $error("shift flag mask");
   AST_CNT_MASK: assert property (sh && i_insn.opcode[7:1] == 7'h69 |=>
      o_result.shift_count == $past(i_insn.count_low[4:0])) else $error("count mask");
   AST_SHR_IMM_MISS: assert property (sh && i_insn.opcode[7:1] == 7'h60 && rg == 3'h5 && mem && i_insn.cache_miss |=>
      o_result.clocks == ($past(i_insn.prot_mode) ? 3'h6 : 3'h5)) else $error("imm right miss time");
   AST_DBL_CL: assert property (esc && (i_insn.opcode inside {8'hA5, 8'hAD}) |=>
      o_result.clocks == (!$past(mem) ? 3'h3 : $past(i_insn.cache_miss) ? 3'h7 : 3'h5)) else $error("double time");
   // Main scenarios
   COV_SHIFT: cover property (sh ##1 o_valid);
   COV_LOCAL: cover property (esc && i_insn.opcode == 8'h00 ##1 o_result.op == OP_STORE_LOCAL_TABLE_REG);
   COV_B2B: cover property (o_valid [*3]);
endmodule
bind shift_store_insn_decode shift_store_insn_decode_monitor shift_store_insn_decode_monitor_i (
   .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_insn(i_insn), .o_valid(o_valid), .o_result(o_result));
`default_nettype wire

// *** bench/shift_store_insn_decode_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module shift_store_insn_decode_test;
   import shift_store_pkg::*;
   // ----------------------------------------
   // Harness
   // ----------------------------------------
   logic        i_core_clk;
   logic        i_rst_n;
   insn_in_t    i_insn;
   logic        o_valid;
   decode_out_t o_result;
   int          miscompares;
   int          n_checks;
   localparam flag_mask_t SH_FL = 6'h3B;
   shift_store_insn_decode shift_store_insn_decode_i (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_insn(i_insn), .o_valid(o_valid), .o_result(o_result));
   // Clock at 25 MHz
   initial begin
      i_core_clk = 1'b0;
      forever #20 i_core_clk = ~i_core_clk;
   end
   task automatic bad(input string m);
      miscompares++;
      $display("BAD t=%0t %s", $time, m);
   endtask
   // Fixed count 25h and imm E3h so the five-bit mask shows
   function automatic insn_in_t mk(input logic e, input logic [7:0] op, input logic [7:0] mr, input logic p,
                                   input logic m, input logic a = 1'b0);
      mk = '0;
      mk.valid = 1'b1;
      mk.escape = e;
      mk.opcode = op;
      mk.modrm = mr;
      mk.sib = 8'h05;
      mk.imm = 8'hE3;
      mk.addr32 = a;
      mk.prot_mode = p;
      mk.cache_miss = m;
      mk.count_low = 8'h25;
   endfunction
   // Drive at the falling edge, judge one cycle later; back to back by design
   task automatic run(input insn_in_t x, input op_t op, input logic [2:0] ck, input logic [3:0] ln,
                      input flag_mask_t fl, input int cnt = -1);
      count_src_t es;
      // Count source follows the opcode form alone; unknown encodings carry none
      case ({x.escape, x.opcode})
         9'h1A4, 9'h1AC, 9'h0C0, 9'h0C1: es = CNT_IMMEDIATE;
         9'h1A5, 9'h1AD, 9'h0D2, 9'h0D3: es = CNT_COUNT_LOW_REGISTER;
         9'h0D0, 9'h0D1:                 es = CNT_ONE;
         default:                        es = CNT_NONE;
      endcase
      if (op == OP_NONE)
         es = CNT_NONE;
      i_insn = x;
      @(negedge i_core_clk);
      n_checks++;
      if (o_valid !== 1'b1 || o_result.valid !== 1'b1 || o_result.op !== op || o_result.clocks !== ck ||
          o_result.flags !== fl ||
          o_result.illegal !== (op == OP_NONE) || o_result.wide !== (!x.escape & x.opcode[0]))
         bad($sformatf("decode %h %h", x.opcode, x.modrm));
      if (op != OP_NONE && o_result.length !== ln)
         bad("length");
      if (o_result.count_src !== es)
         bad("count source");
      if (o_result.shift_count !== (cnt >= 0 ? cnt[4:0] : 5'h00))
         bad("count");
   endtask
   task automatic idle();
      i_insn.valid = 1'b0;
      @(negedge i_core_clk);
      n_checks++;
      if (o_valid !== 1'b0 || o_result.valid !== 1'b0 || o_result.illegal !== 1'b0)
         bad("valid after idle");
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_set_byte();
      run(mk(1, 8'h98, 8'hC0, 0, 0), OP_SET_BYTE_ON_NEGATIVE, 3'h2, 4'h3, '0);
      run(mk(1, 8'h98, 8'h06, 1, 1), OP_SET_BYTE_ON_NEGATIVE, 3'h2, 4'h5, '0);
      run(mk(1, 8'h99, 8'hC0, 0, 0), OP_NONE, 3'h0, 4'h3, '0);
   endtask
   task automatic t_stores();
      run(mk(1, 8'h01, 8'h06, 0, 1), OP_STORE_GLOBAL_TABLE_REG, 3'h6, 4'h5, '0);
      run(mk(1, 8'h01, 8'hC8, 1, 0), OP_STORE_INTERRUPT_TABLE_REG, 3'h6, 4'h3, '0);
      run(mk(1, 8'h01, 8'hE0, 0, 0), OP_STORE_MACHINE_STATUS, 3'h1, 4'h3, '0);
      run(mk(1, 8'h01, 8'h66, 1, 0), OP_STORE_MACHINE_STATUS, 3'h2, 4'h4, '0);
      run(mk(1, 8'h01, 8'h26, 0, 1), OP_STORE_MACHINE_STATUS, 3'h2, 4'h5, '0);
      run(mk(1, 8'h00, 8'hC0, 1, 0), OP_STORE_LOCAL_TABLE_REG, 3'h1, 4'h3, '0);
      run(mk(1, 8'h00, 8'h46, 1, 1), OP_STORE_LOCAL_TABLE_REG, 3'h2, 4'h4, '0);
      run(mk(1, 8'h00, 8'hC0, 0, 0), OP_NONE, 3'h0, 4'h3, '0);
   endtask
   // Forms by one, by count, by imm; levels reg, hit, real miss, prot miss
   task automatic t_single();
      logic [7:0] opc[3] = '{8'hD1, 8'hD3, 8'hC1};
      logic [2:0] ck;
      for (int r = 0; r < 2; r++) begin
         for (int f = 0; f < 3; f++) begin
            for (int m = 0; m < 4; m++) begin
               ck = (f == 1 ? 3'h3 : 3'h2) + (m == 0 ? 3'h0 : m == 1 ? 3'h2 : 3'h4);
               if (r == 1 && f == 2 && m == 2)
                  ck = 3'h5;
               run(mk(0, opc[f], {(m == 0 ? 2'h3 : 2'h1), 1'b1, 1'b0, r[0], 3'h0}, m == 3, m > 1),
                   r ? OP_SHIFT_RIGHT_LOGICAL : OP_SHIFT_LEFT_LOGICAL, ck, 4'(2 + (f == 2) + (m > 0)),
                   SH_FL, f == 0 ? 1 : f == 1 ? 5 : 3);
            end
         end
      end
      run(mk(0, 8'hD0, 8'hE0, 0, 0), OP_SHIFT_LEFT_LOGICAL, 3'h2, 4'h2, SH_FL, 1);
   endtask
   task automatic t_double();
      logic [7:0] opc[4] = '{8'hA4, 8'hA5, 8'hAC, 8'hAD};
      for (int i = 0; i < 4; i++) begin
         for (int m = 0; m < 3; m++) begin
            run(mk(1, opc[i], m == 0 ? 8'hC0 : 8'h40, 0, m == 2),
                i < 2 ? OP_SHIFT_LEFT_DOUBLE : OP_SHIFT_RIGHT_DOUBLE, 3'(1 + 2 * (i % 2) + 2 * m),
                4'(3 + (i % 2 == 0) + (m > 0)), SH_FL, i % 2 ? 5 : 3);
         end
      end
   endtask
   // Reset in mid-run with a valid instruction waiting; it must not leak through
   task automatic t_reset();
      i_insn = mk(0, 8'hD3, 8'hE0, 0, 0);
      i_rst_n = 1'b0;
      @(negedge i_core_clk);
      n_checks++;
      if (o_valid !== 1'b0 || o_result !== '0)
         bad("mid-run reset outputs");
      i_rst_n = 1'b1;
      run(mk(0, 8'hD3, 8'hE0, 0, 0), OP_SHIFT_LEFT_LOGICAL, 3'h3, 4'h2, SH_FL, 5);
   endtask
   task automatic t_length();
      run(mk(0, 8'hD3, 8'hA0, 0, 0, 1), OP_SHIFT_LEFT_LOGICAL, 3'h5, 4'h6, SH_FL, 5);
      run(mk(0, 8'hC1, 8'h24, 0, 0, 1), OP_SHIFT_LEFT_LOGICAL, 3'h4, 4'h8, SH_FL, 3);
      run(mk(0, 8'hD1, 8'h25, 0, 0, 1), OP_SHIFT_LEFT_LOGICAL, 3'h4, 4'h6, SH_FL, 1);
      run(mk(0, 8'hC1, 8'hA6, 0, 0, 0), OP_SHIFT_LEFT_LOGICAL, 3'h4, 4'h5, SH_FL, 3);
   endtask
   task automatic give_verdict();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      miscompares = 0;
      n_checks = 0;
      i_rst_n = 1'b0;
      i_insn = '0;
      repeat (4) @(negedge i_core_clk);
      n_checks++;
      if (o_valid !== 1'b0 || o_result !== '0)
         bad("reset outputs");
      i_rst_n = 1'b1;
      t_set_byte();
      idle();
      t_stores();
      t_single();
      t_double();
      t_reset();
      t_length();
      idle();
      give_verdict();
   end
endmodule
`default_nettype wire
